// ---- core/spio_defs_defs.svh ----
// Purpose: Shared constants of the serial machine I/O expander.
// Assumes: One system clock mclk; all processor bus pins are asynchronous to it.
// Notes: Offsets, field positions, reset values and counts only; no logic lives here.
// Behaviour
// - Output states travel from processor to boards only bit by bit over the serial bus; input states also reach the image memory directly from the pins.
// - The first board's 63 inputs are multiplexed onto the first return line, picked by the bus address.
// - A second board's inputs are multiplexed onto their own second return line, apart from the first.
// - The interface side picks the first or second return line and forwards it to the processor's input.
// - The serial output stream is converted into 31 parallel machine outputs by a shift stage.
// - Each driven output is supervised and is off only while its own overload lasts, then resumes its command; the emergency-stop output is not supervised.
// - Any overloaded output is reported on a dedicated input bit, read through the same multiplexer.
// - One variant has 26 unipolar plus 5 bipolar outputs, the other 31 unipolar plus an emergency-stop output.
// - All input and output states are mirrored in an 8k by 8 image memory that the processor works on.
// - The direct configuration has 24 inputs and 24 relays, the last relay being the emergency-stop output.
`ifndef SPIO_DEFS_DEFS_SVH
`define SPIO_DEFS_DEFS_SVH

// Board geometry.
`define SPIO_NUM_OUT 31
`define SPIO_NUM_IN 63
`define SPIO_SEL_W 6
`define SPIO_OVL_SEL 6'h3f
`define SPIO_UNIPOLAR_VAR 26
`define SPIO_BIPOLAR_CNT 5
`define SPIO_DIRECT_CNT 24
`define SPIO_BOARDS 2

// Image memory layout.
`define SPIO_RAM_WORDS 8192
`define SPIO_RAM_AW 13
`define SPIO_RAM_DW 8
`define SPIO_IN_BASE 13'h0000
`define SPIO_OUT_BASE 13'h0010
`define SPIO_IN_LAST 4'hf
`define SPIO_OUT_LAST 4'h3

// Reset values.
`define SPIO_OUT_RESET 1'b0
`define SPIO_RET_RESET 1'b0

`endif

// ---- core/spio_end.sv ----
// Purpose: Closes the list of design files; it holds no logic.
// Assumes: Nothing; no module is declared here.
// Notes: The expander's modules live in their own files.

// ---- core/spio_in_mux.sv ----
// Purpose: Address-selected input multiplexer for one or two boards.
// Assumes: Input pins arrive filtered and on mclk.
// Notes: Selector 63 of a board returns that board's overload flag.
`include "spio_defs_defs.svh"

module spio_in_mux import spio_pkg::*; #(
	parameter int NUM_IN = `SPIO_NUM_IN,
	parameter int BOARDS = `SPIO_BOARDS,
	parameter bit DIRECT_IO = 1'b0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Sampled serial bus.
	spio_ser_if.ins bus,
	// Filtered board inputs.
	input wire logic [NUM_IN-1:0] first_inputs,
	input wire logic [NUM_IN-1:0] second_inputs,
	input wire logic second_overload
);

	localparam int LIVE = DIRECT_IO ? `SPIO_DIRECT_CNT : NUM_IN;
	localparam bit HAS_SECOND = (BOARDS > 1) && !DIRECT_IO;

	if (NUM_IN > `SPIO_NUM_IN || NUM_IN < `SPIO_DIRECT_CNT || BOARDS < 1 || BOARDS > 2) begin : g_bad_cfg
		$error("spio_in_mux: unsupported input count or board count");
	end

	// One board's return line: a live input, the overload flag, or zero for unfitted bits.
	function automatic logic pick(input logic [NUM_IN-1:0] vec, input spio_sel_t sel, input logic ovl);
		logic r;
		r = 1'b0;
		if (sel == `SPIO_OVL_SEL) begin
			r = ovl;
		end else if (int'(sel) < LIVE) begin
			r = vec[sel];
		end
		return r;
	endfunction : pick

	// Each board keeps its own line; the board select then forwards one of them.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus.ret_bit <= `SPIO_RET_RESET;
		end else if (bus.board_sel) begin
			bus.ret_bit <= HAS_SECOND ? pick(second_inputs, bus.bit_sel, second_overload) : 1'b0;
		end else begin
			bus.ret_bit <= pick(first_inputs, bus.bit_sel, bus.overload_any);
		end
	end

	AST_OVL_BIT: assert property (@(posedge mclk) disable iff (!reset_n)
		!bus.board_sel && bus.bit_sel == `SPIO_OVL_SEL |=> bus.ret_bit == $past(bus.overload_any))
		else $error("Overload flag not returned on its input bit");
	AST_BOARD_SEP: assert property (@(posedge mclk) disable iff (!reset_n)
		bus.board_sel && bus.bit_sel == 6'h00 |=> bus.ret_bit == (HAS_SECOND && $past(second_inputs[0])))
		else $error("Second board line mixed with the first");
	AST_FIRST_LINE: assert property (@(posedge mclk) disable iff (!reset_n)
		!bus.board_sel && bus.bit_sel == 6'h05 |=> bus.ret_bit == $past(first_inputs[5]))
		else $error("First board input not selected by address");

endmodule : spio_in_mux

// ---- core/spio_out_stage.sv ----
// Purpose: Serial-to-parallel output stage with per-output overload cut-off.
// Assumes: Overcurrent senses arrive filtered and on mclk.
// Notes: A frame is NUM_OUT+1 bits, first bit shifted lands in the top (emergency-stop) position.
`include "spio_defs_defs.svh"

module spio_out_stage import spio_pkg::*; #(
	parameter int NUM_OUT = `SPIO_NUM_OUT,
	parameter spio_variant_e VARIANT = VAR_ESTOP,
	parameter bit DIRECT_IO = 1'b0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Sampled serial bus.
	spio_ser_if.outs bus,
	// Filtered overcurrent sense, one per output.
	input wire logic [NUM_OUT-1:0] overcurrent,
	// Machine side.
	output logic [NUM_OUT-1:0] drive,
	output logic estop_ok,
	output logic [`SPIO_BIPOLAR_CNT-1:0] bipolar_enable
);

	localparam int FRAME = NUM_OUT + 1;
	localparam int CW = $clog2(FRAME + 1);
	localparam logic [CW-1:0] FULL = CW'(FRAME);
	localparam int DLAST = `SPIO_DIRECT_CNT - 1;
	localparam int UNI = `SPIO_UNIPOLAR_VAR;
	localparam logic [NUM_OUT-1:0] USE_MASK = DIRECT_IO ? NUM_OUT'((64'h1 << DLAST) - 64'h1) : '1;

	logic [FRAME-1:0] shreg;
	logic [FRAME-1:0] latch;
	logic [CW-1:0] cnt;

	// The variant split and the direct relay count only fit the documented board width.
	if (NUM_OUT != UNI + `SPIO_BIPOLAR_CNT) begin : g_bad_width
		$error("spio_out_stage: NUM_OUT must equal unipolar plus bipolar count");
	end

	// Bits enter one at a time; there is no parallel load path.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= '0;
		end else if (bus.wr_pulse) begin
			shreg <= {shreg[FRAME-2:0], bus.wr_data};
		end
	end

	// Bit counter; a latch strobe always starts a fresh frame, keeping a bit shifted in the same cycle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
		end else if (bus.latch_pulse) begin
			cnt <= bus.wr_pulse ? CW'(1) : '0;
		end else if (bus.wr_pulse && cnt != FULL) begin
			cnt <= cnt + CW'(1);
		end
	end

	// Only a complete frame is taken; a short one is dropped so the outputs never show half a set.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			latch <= '0;
		end else if (bus.latch_pulse && cnt == FULL) begin
			latch <= shreg;
		end
	end

	// Overload gates the command each cycle, so the output comes back on its own when the overload ends.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			drive <= '0;
		end else begin
			drive <= latch[NUM_OUT-1:0] & ~overcurrent & USE_MASK;
		end
	end

	// Emergency-stop relay sits above the last unipolar output, or on the 24th relay when direct.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			estop_ok <= `SPIO_OUT_RESET;
		end else if (VARIANT == VAR_ESTOP) begin
			estop_ok <= DIRECT_IO ? latch[DLAST] : latch[NUM_OUT];
		end else begin
			estop_ok <= `SPIO_OUT_RESET;
		end
	end

	// Bipolar outputs carry polarity on drive; their enable drops while overloaded.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bipolar_enable <= '0;
			bus.overload_any <= 1'b0;
		end else begin
			bipolar_enable <= (VARIANT == VAR_BIPOLAR) ? ~overcurrent[NUM_OUT-1:UNI] : '0;
			bus.overload_any <= |(overcurrent & USE_MASK);
		end
	end

	sequence s_full_latch;
		bus.latch_pulse && cnt == FULL;
	endsequence

	AST_SHIFT_IN: assert property (@(posedge mclk) disable iff (!reset_n)
		bus.wr_pulse |=> shreg[0] == $past(bus.wr_data) && shreg[FRAME-1:1] == $past(shreg[FRAME-2:0]))
		else $error("Shift stage did not take the serial bit");
	AST_FRAME_TAKE: assert property (@(posedge mclk) disable iff (!reset_n)
		s_full_latch |=> latch == $past(shreg) ##1 drive == ($past(latch[NUM_OUT-1:0]) & ~$past(overcurrent) & USE_MASK))
		else $error("Complete frame did not reach the outputs");
	AST_PARTIAL_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
		!(bus.latch_pulse && cnt == FULL) |=> $stable(latch))
		else $error("Output set changed without a complete frame");
	AST_OVL_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
		overcurrent[0] && !DIRECT_IO |=> !drive[0] ##1 ($past(overcurrent[0]) || drive[0] == $past(latch[0])))
		else $error("Overloaded output not cut off or not resumed");
	AST_DIRECT_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
		DIRECT_IO |-> drive[NUM_OUT-1:DLAST] == '0)
		else $error("Relay beyond the direct set is driven");
	AST_VARIANT: assert property (@(posedge mclk) disable iff (!reset_n)
		VARIANT == VAR_BIPOLAR |-> !estop_ok && bipolar_enable == ~$past(overcurrent[NUM_OUT-1:UNI]))
		else $error("Bipolar variant output set wrong");

endmodule : spio_out_stage

// ---- core/spio_pkg.sv ----
// Purpose: Types shared by the expander modules.
// Assumes: The constants header is visible on the include path.
// Notes: Constants stay in the header; this package carries types only.
`include "spio_defs_defs.svh"

package spio_pkg;

	// Image scanner phases.
	typedef enum {SCAN_IN, SCAN_OUT} spio_scan_e;

	// Board output variant.
	typedef enum {VAR_ESTOP, VAR_BIPOLAR} spio_variant_e;

	// Input bit selector and image byte.
	typedef logic [`SPIO_SEL_W-1:0] spio_sel_t;
	typedef logic [`SPIO_RAM_DW-1:0] spio_byte_t;

endpackage : spio_pkg

// ---- core/spio_ser_if.sv ----
// Purpose: Carries the sampled serial bus between the expander's own modules.
// Assumes: Every signal is on mclk and already free of metastability.
// Notes: Strobes are one-cycle pulses; selectors are levels.
interface spio_ser_if;
	import spio_pkg::*;

	spio_sel_t bit_sel;
	logic board_sel;
	logic wr_pulse;
	logic wr_data;
	logic latch_pulse;
	logic overload_any;
	logic ret_bit;

	modport ctrl(output bit_sel, board_sel, wr_pulse, wr_data, latch_pulse, input overload_any, ret_bit);
	modport outs(input wr_pulse, wr_data, latch_pulse, output overload_any);
	modport ins(input bit_sel, board_sel, overload_any, output ret_bit);

endinterface : spio_ser_if

// ---- core/spio_top.sv ----
// Purpose: Serial machine I/O expander: output shift stage, input multiplexer and state image memory.
// Assumes: Processor bus pins and board pins are asynchronous to mclk; image port is on mclk.
// Notes: Every top output leaves from a flip-flop; image memory is flip-flop storage.
// Notes: A strobe level shorter than two clocks may be lost in the pin filter.
`include "spio_defs_defs.svh"

module spio_top import spio_pkg::*; #(
	parameter int NUM_OUT = `SPIO_NUM_OUT,
	parameter int NUM_IN = `SPIO_NUM_IN,
	parameter int BOARDS = `SPIO_BOARDS,
	parameter spio_variant_e VARIANT = VAR_ESTOP,
	parameter bit DIRECT_IO = 1'b0,
	parameter int RAM_WORDS = `SPIO_RAM_WORDS
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Serial bus from the processor.
	input wire logic [`SPIO_SEL_W:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_latch,
	input wire logic processor_serial_output,
	output logic processor_serial_input,
	// Board inputs.
	input wire logic [NUM_IN-1:0] programmable_inputs,
	input wire logic [NUM_IN-1:0] second_board_inputs,
	input wire logic second_board_overload,
	// Machine outputs and their supervision.
	input wire logic [NUM_OUT-1:0] overcurrent_sense,
	output logic [NUM_OUT-1:0] relay_outputs,
	output logic estop_ok,
	output logic [`SPIO_BIPOLAR_CNT-1:0] bipolar_enable,
	// State image port.
	input wire logic [`SPIO_RAM_AW-1:0] ram_addr,
	input wire logic [`SPIO_RAM_DW-1:0] ram_wdata,
	input wire logic ram_we,
	output logic [`SPIO_RAM_DW-1:0] ram_rdata
);

	// Layout of the packed pin vector that goes through the synchroniser.
	localparam int AW = $clog2(RAM_WORDS);
	localparam int P_ADDR = 0;
	localparam int P_WR = P_ADDR + `SPIO_SEL_W + 1;
	localparam int P_LATCH = P_WR + 1;
	localparam int P_DATA = P_LATCH + 1;
	localparam int P_IN1 = P_DATA + 1;
	localparam int P_IN2 = P_IN1 + NUM_IN;
	localparam int P_OVL2 = P_IN2 + NUM_IN;
	localparam int P_OC = P_OVL2 + 1;
	localparam int PIN_W = P_OC + NUM_OUT;

	// The image is addressed by the processor's full address; smaller memories only for simulation.
	if (RAM_WORDS != (1 << AW) || RAM_WORDS > `SPIO_RAM_WORDS || AW < 5) begin : g_bad_ram
		$error("spio_top: RAM_WORDS must be a power of two between 32 and 8192");
	end
	if (NUM_OUT + 1 > 32) begin : g_bad_out
		$error("spio_top: output image holds at most 32 bits");
	end

	// Internal serial bus shared by the three parts of the expander.
	spio_ser_if bus ();

	// Synchroniser stages, edge memories, scanner state and the image itself.
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_f;
	logic wr_seen;
	logic latch_seen;
	spio_scan_e scan_state;
	logic [3:0] scan_idx;
	logic [`SPIO_RAM_AW-1:0] scan_addr;
	spio_byte_t scan_data;
	spio_byte_t image [RAM_WORDS];

	// A filtered bit only moves once the second and third stages agree.
	function automatic logic [PIN_W-1:0] settle(input logic [PIN_W-1:0] a, input logic [PIN_W-1:0] b,
			input logic [PIN_W-1:0] held);
		return (~(a ^ b) & b) | ((a ^ b) & held);
	endfunction : settle

	// Picks one byte out of a 64-bit image row.
	function automatic spio_byte_t byte_of(input logic [63:0] v, input logic [2:0] i);
		return v[{i, 3'b000} +: `SPIO_RAM_DW];
	endfunction : byte_of

	// All asynchronous pins gathered so one synchroniser serves them.
	assign pin_raw = {overcurrent_sense, second_board_overload, second_board_inputs, programmable_inputs,
		processor_serial_output, bus_latch, bus_write, bus_addr};

	// Three-stage synchroniser; stage one feeds stage two only.
	// Reading stage one anywhere else would expose logic to a metastable value.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Glitch filter: a one-sample disagreement never reaches the logic.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_f <= '0;
		end else begin
			pin_f <= settle(pin_s2, pin_s3, pin_f);
		end
	end

	// Strobes become single pulses on their rising edge; the data bit is taken with them.
	// Only rising edges count, so a strobe held high for many cycles shifts exactly once.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_seen <= 1'b0;
			latch_seen <= 1'b0;
			bus.wr_pulse <= 1'b0;
			bus.latch_pulse <= 1'b0;
			bus.wr_data <= 1'b0;
		end else begin
			wr_seen <= pin_f[P_WR];
			latch_seen <= pin_f[P_LATCH];
			bus.wr_pulse <= pin_f[P_WR] & ~wr_seen;
			bus.latch_pulse <= pin_f[P_LATCH] & ~latch_seen;
			bus.wr_data <= pin_f[P_DATA];
		end
	end

	// Address splits into input bit and board line.
	// Registering the split keeps the return path one flip-flop deep between stages.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus.bit_sel <= '0;
			bus.board_sel <= 1'b0;
		end else begin
			bus.bit_sel <= pin_f[P_ADDR +: `SPIO_SEL_W];
			bus.board_sel <= pin_f[P_ADDR + `SPIO_SEL_W];
		end
	end

	// The selected line goes back on the single serial input.
	// The output flip-flop keeps the pin free of glitches while the select moves.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			processor_serial_input <= `SPIO_RET_RESET;
		end else begin
			processor_serial_input <= bus.ret_bit;
		end
	end

	// Output shift stage with supervision.
	spio_out_stage #(
		.NUM_OUT(NUM_OUT),
		.VARIANT(VARIANT),
		.DIRECT_IO(DIRECT_IO)
	) u_out (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus(bus.outs),
		.overcurrent(pin_f[P_OC +: NUM_OUT]),
		.drive(relay_outputs),
		.estop_ok(estop_ok),
		.bipolar_enable(bipolar_enable)
	);

	// Input multiplexer for one or two boards.
	spio_in_mux #(
		.NUM_IN(NUM_IN),
		.BOARDS(BOARDS),
		.DIRECT_IO(DIRECT_IO)
	) u_in (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus(bus.ins),
		.first_inputs(pin_f[P_IN1 +: NUM_IN]),
		.second_inputs(pin_f[P_IN2 +: NUM_IN]),
		.second_overload(pin_f[P_OVL2])
	);

	// Scanner walks sixteen input bytes, then four output bytes, pausing whenever the processor writes.
	// A full pass takes twenty free cycles, so software writes into scanned bytes do not last.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			scan_state <= SCAN_IN;
			scan_idx <= '0;
		end else if (!ram_we) begin
			case (scan_state)
				SCAN_IN: begin
					if (scan_idx == `SPIO_IN_LAST) begin
						scan_state <= SCAN_OUT;
						scan_idx <= '0;
					end else begin
						scan_idx <= scan_idx + 4'h1;
					end
				end
				SCAN_OUT: begin
					if (scan_idx == `SPIO_OUT_LAST) begin
						scan_state <= SCAN_IN;
						scan_idx <= '0;
					end else begin
						scan_idx <= scan_idx + 4'h1;
					end
				end
				default: begin
					scan_state <= SCAN_IN;
					scan_idx <= '0;
				end
			endcase
		end
	end

	// Image bytes: each board's row ends with its overload flag in bit 63.
	always_comb begin
		logic [63:0] row1;
		logic [63:0] row2;
		logic [63:0] row_out;
		row1 = {bus.overload_any, 63'(pin_f[P_IN1 +: NUM_IN])};
		row2 = {pin_f[P_OVL2], 63'(pin_f[P_IN2 +: NUM_IN])};
		row_out = 64'({estop_ok, relay_outputs});
		case (scan_state)
			SCAN_IN: begin
				scan_addr = `SPIO_IN_BASE + `SPIO_RAM_AW'(scan_idx);
				scan_data = scan_idx[3] ? byte_of(row2, scan_idx[2:0]) : byte_of(row1, scan_idx[2:0]);
			end
			SCAN_OUT: begin
				scan_addr = `SPIO_OUT_BASE + `SPIO_RAM_AW'(scan_idx);
				scan_data = byte_of(row_out, scan_idx[2:0]);
			end
			default: begin
				scan_addr = `SPIO_IN_BASE;
				scan_data = '0;
			end
		endcase
	end

	// Processor writes win the single write port; the scanner retries the same byte next cycle.
	// The image has no reset; bytes outside the scanned area hold only what software wrote.
	always_ff @(posedge mclk) begin
		if (ram_we) begin
			image[ram_addr[AW-1:0]] <= ram_wdata;
		end else begin
			image[scan_addr[AW-1:0]] <= scan_data;
		end
	end

	// Registered read port, one cycle after the address.
	// A write and a read of one address in one cycle return the old byte.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ram_rdata <= '0;
		end else begin
			ram_rdata <= image[ram_addr[AW-1:0]];
		end
	end

	sequence s_wr_then_read;
		ram_we ##1 (!ram_we && ram_addr == $past(ram_addr));
	endsequence

	sequence s_in_done;
		scan_state == SCAN_IN && scan_idx == `SPIO_IN_LAST && !ram_we;
	endsequence

	AST_RAM_READBACK: assert property (@(posedge mclk) disable iff (!reset_n)
		s_wr_then_read |=> ram_rdata == $past(ram_wdata, 2))
		else $error("Image memory lost a processor write");
	AST_SCAN_YIELD: assert property (@(posedge mclk) disable iff (!reset_n)
		ram_we |=> scan_idx == $past(scan_idx) && scan_state == $past(scan_state))
		else $error("Scanner advanced during a processor write");
	AST_SCAN_WRAP: assert property (@(posedge mclk) disable iff (!reset_n)
		s_in_done |=> scan_state == SCAN_OUT && scan_idx == 4'h0)
		else $error("Scanner did not move on to the output bytes");
	AST_WR_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
		bus.wr_pulse |=> !bus.wr_pulse)
		else $error("Write strobe produced more than one shift");
	AST_RETURN_PATH: assert property (@(posedge mclk) disable iff (!reset_n)
		!bus.board_sel && bus.bit_sel == `SPIO_OVL_SEL ##1 1 |=> processor_serial_input == $past(bus.overload_any, 2))
		else $error("Selected return line not forwarded to the processor");

	// Scanner must come back to the first input byte after the last output byte.
	sequence s_out_done;
		scan_state == SCAN_OUT && scan_idx == `SPIO_OUT_LAST && !ram_we;
	endsequence

	// A write pin whose last two stages disagree must leave the filtered value alone.
	sequence s_wr_unsettled;
		pin_s2[P_WR] != pin_s3[P_WR];
	endsequence

	AST_SCAN_BACK: assert property (@(posedge mclk) disable iff (!reset_n)
		s_out_done |=> scan_state == SCAN_IN && scan_idx == 4'h0)
		else $error("Scanner did not return to the input bytes");
	AST_OUT_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
		scan_state == SCAN_OUT |-> scan_idx <= `SPIO_OUT_LAST)
		else $error("Scanner ran past the last output byte");
	AST_LATCH_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
		bus.latch_pulse |=> !bus.latch_pulse)
		else $error("Latch strobe produced more than one transfer");
	AST_WR_FILTER: assert property (@(posedge mclk) disable iff (!reset_n)
		s_wr_unsettled |=> pin_f[P_WR] == $past(pin_f[P_WR]))
		else $error("Write strobe passed the filter before it settled");

endmodule : spio_top

// ---- tb/spio_proc_model.sv ----
// Purpose: Processor side of the serial bus, shifting frames and steering the return select.
// Assumes: The bench calls these tasks one at a time; pins change only at falling edges.
// Notes: Strobes are held 4 cycles high and at least 4 low, well above the synchroniser's minimum.
`include "spio_defs_defs.svh"

module spio_proc_model import spio_pkg::*; (
	// Clock.
	input wire logic mclk,
	// Serial bus pins.
	output logic [`SPIO_SEL_W:0] bus_addr,
	output logic bus_write,
	output logic bus_latch,
	output logic processor_serial_output
);
	timeunit 1ns;
	timeprecision 1ns;

	// All pins start idle.
	initial begin
		bus_addr = 7'h00;
		bus_write = 1'b0;
		bus_latch = 1'b0;
		processor_serial_output = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask : idle

	// Moves the select lines; the return bit follows the address only.
	task automatic set_addr(input logic [`SPIO_SEL_W:0] a);
		@(negedge mclk);
		bus_addr = a;
	endtask : set_addr

	// One bit per write strobe, never a parallel path.
	task automatic send_bit(input logic b);
		@(negedge mclk);
		processor_serial_output = b;
		idle(3);
		bus_write = 1'b1;
		idle(4);
		bus_write = 1'b0;
		idle(4);
		// The data line is no longer valid, so it shows the inverse rather than a stale copy.
		processor_serial_output = ~b;
	endtask : send_bit

	// Top bit first, so the emergency-stop bit leads the frame.
	// The model never asks for an emergency stop on its own account.
	task automatic send_frame(input logic [31:0] frame, input int nbits);
		for (int i = nbits - 1; i >= 0; i--) begin
			send_bit(frame[i]);
		end
		bus_latch = 1'b1;
		idle(4);
		bus_latch = 1'b0;
		idle(4);
	endtask : send_frame

endmodule : spio_proc_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the serial expander top with a processor model.
// Assumes: The image memory is shrunk to 32 words; inputs scan to bytes 0-15, outputs to bytes 16-19.
// Notes: Select cases and frames are table rows; reset, short frame, overload and image are hand-written.
`include "spio_defs_defs.svh"

module testbench import spio_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {logic [6:0] addr; logic exp;} spio_sel_row_s;
	typedef struct packed {logic [31:0] frame; logic [31:0] exp;} spio_frm_row_s;

	logic mclk;
	logic reset_n;
	wire logic [6:0] bus_addr;
	wire logic bus_write;
	wire logic bus_latch;
	wire logic processor_serial_output;
	logic processor_serial_input;
	logic [62:0] programmable_inputs;
	logic [62:0] second_board_inputs;
	logic second_board_overload;
	logic [30:0] overcurrent_sense;
	logic [30:0] relay_outputs;
	logic estop_ok;
	logic [4:0] bipolar_enable;
	logic [12:0] ram_addr;
	logic [7:0] ram_wdata;
	logic ram_we;
	logic [7:0] ram_rdata;
	int miscompares = 0;
	int checks = 0;

	// Board one bits alternate 0,1 from bit 0; board two the opposite; board two reports overload.
	localparam spio_sel_row_s SEL_ROWS [8] = '{'{7'h00, 1'b0}, '{7'h01, 1'b1}, '{7'h3e, 1'b0},
		'{7'h40, 1'b1}, '{7'h41, 1'b0}, '{7'h7e, 1'b1}, '{7'h3f, 1'b0}, '{7'h7f, 1'b1}};
	localparam spio_frm_row_s FRM_ROWS [3] = '{'{32'h8000_0001, 32'h8000_0001},
		'{32'h7fff_fffe, 32'h7fff_fffe}, '{32'h5a5a_a5a5, 32'h5a5a_a5a5}};

	spio_proc_model proc (
		.mclk(mclk),
		.bus_addr(bus_addr),
		.bus_write(bus_write),
		.bus_latch(bus_latch),
		.processor_serial_output(processor_serial_output)
	);

	spio_top #(.RAM_WORDS(32)) dut (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus_addr(bus_addr),
		.bus_write(bus_write),
		.bus_latch(bus_latch),
		.processor_serial_output(processor_serial_output),
		.processor_serial_input(processor_serial_input),
		.programmable_inputs(programmable_inputs),
		.second_board_inputs(second_board_inputs),
		.second_board_overload(second_board_overload),
		.overcurrent_sense(overcurrent_sense),
		.relay_outputs(relay_outputs),
		.estop_ok(estop_ok),
		.bipolar_enable(bipolar_enable),
		.ram_addr(ram_addr),
		.ram_wdata(ram_wdata),
		.ram_we(ram_we),
		.ram_rdata(ram_rdata)
	);

	// Free-running 20 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic wrap_up;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	// A hang is cut short well inside the run budget.
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		programmable_inputs = 63'h2aaa_aaaa_aaaa_aaaa;
		second_board_inputs = 63'h5555_5555_5555_5555;
		second_board_overload = 1'b1;
		overcurrent_sense = 31'h0;
		ram_addr = 13'h0000;
		ram_wdata = 8'h00;
		ram_we = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
		cmp_word({estop_ok, relay_outputs}, 32'h0);
		cmp_bit(processor_serial_input, 1'b0);
		@(negedge mclk);
		reset_n = 1'b1;
		cyc(2);
		// The return bit settles 7 edges after the select moves; 10 leaves margin.
		foreach (SEL_ROWS[i]) begin
			proc.set_addr(SEL_ROWS[i].addr);
			cyc(10);
			cmp_bit(processor_serial_input, SEL_ROWS[i].exp);
		end
		foreach (FRM_ROWS[i]) begin
			proc.send_frame(FRM_ROWS[i].frame, 32);
			cyc(10);
			cmp_word({estop_ok, relay_outputs}, FRM_ROWS[i].exp);
		end
		// A frame one bit short must leave the outputs as they were.
		proc.send_frame(32'h0000_0000, 31);
		cyc(10);
		cmp_word({estop_ok, relay_outputs}, 32'h5a5a_a5a5);
		// Overload on a driven output cuts it only while the sense stays high.
		proc.set_addr(7'h3f);
		overcurrent_sense = 31'h0000_0001;
		cyc(12);
		cmp_word({estop_ok, relay_outputs}, 32'h5a5a_a5a4);
		cmp_bit(processor_serial_input, 1'b1);
		cmp_word({27'h0, bipolar_enable}, 32'h0);
		overcurrent_sense = 31'h0;
		cyc(12);
		cmp_word({estop_ok, relay_outputs}, 32'h5a5a_a5a5);
		cmp_bit(processor_serial_input, 1'b0);
		// Image memory: a free word, then scanned input and output bytes.
		ram_addr = 13'h0018;
		ram_wdata = 8'ha5;
		ram_we = 1'b1;
		cyc(1);
		ram_we = 1'b0;
		cyc(2);
		cmp_word({24'h0, ram_rdata}, 32'h0000_00a5);
		ram_addr = 13'h0000;
		cyc(30);
		cmp_word({24'h0, ram_rdata}, 32'h0000_00aa);
		ram_addr = 13'h0013;
		cyc(30);
		cmp_word({24'h0, ram_rdata}, 32'h0000_005a);
		wrap_up();
	end

endmodule : testbench
